// ---- sle_pkg.sv ----
// Constants, types and register map for the synthesizer lock and frequency control
// Overview of operation
// - Lock and unlock events appear as two flags in status register 0x0F.
// - Raising either event clears the other pending flag.
// - Lock event on leaving radio off into active idle, or after frequency change there.
// - Lock event when a manually started center-frequency calibration completes.
// - Otherwise lock event only when lock returns after a loss of lock.
// - Unlock event on manual center calibration start or frequency change in synth-on/listen.
// - Any event while transmitting aborts transmission and forces synth-on state.
// - Any event while receiving returns to the matching idle state once locked.
// - No lock event during settling after a successful transmission.
// - Channel field bits 4:0 reset 0x0B; 0x0B to 0x1A select 2405 MHz upward.
// - Eight-bit alternative index reset 0x00; valid ranges depend on band 8 or 9.
// - Band selector bits 3:0; upper bits read zero; 0, 8, 9 valid.
// - Center calibration start bit 7 runs about 8 us and clears itself.
// - Delay-cell calibration start bit 7 runs about 6 us and clears itself.
// - Bands 8 and 9 tune to 2306 or 2434 MHz plus half MHz times index.
// - Any move to a new frequency setting starts both calibrations.
package sle_pkg;
   // Register offsets
   localparam logic [5:0] SLE_ADDR_CHAN = 6'h08;
   localparam logic [5:0] SLE_ADDR_IRQ = 6'h0f;
   localparam logic [5:0] SLE_ADDR_NUM = 6'h13;
   localparam logic [5:0] SLE_ADDR_BAND = 6'h14;
   localparam logic [5:0] SLE_ADDR_CF = 6'h1a;
   localparam logic [5:0] SLE_ADDR_DCU = 6'h1b;
   // Reset values
   localparam logic [7:0] SLE_RST_CHAN = 8'h2b;
   localparam logic [7:0] SLE_RST_NUM = 8'h00;
   localparam logic [3:0] SLE_RST_BAND = 4'h0;
   localparam logic [7:0] SLE_RST_CF = 8'h57;
   localparam logic [7:0] SLE_RST_DCU = 8'h20;
   // Field positions
   localparam int SLE_BIT_LOCK = 0;
   localparam int SLE_BIT_UNLOCK = 1;
   localparam int SLE_BIT_GO = 7;
   localparam int SLE_BIT_DCU_RO = 6;
   // Bands and channel limits
   localparam logic [3:0] SLE_BAND_CHAN = 4'h0;
   localparam logic [3:0] SLE_BAND_LO = 4'h8;
   localparam logic [3:0] SLE_BAND_HI = 4'h9;
   localparam logic [4:0] SLE_CHAN_MIN = 5'h0b;
   localparam logic [4:0] SLE_CHAN_MAX = 5'h1a;
   localparam logic [7:0] SLE_LO_MIN = 8'h20;
   localparam logic [7:0] SLE_HI_MAX = 8'hba;
   // Frequencies in half-megahertz units
   localparam int SLE_FW = 13;
   localparam logic [12:0] SLE_F_CHAN_BASE = 13'h12ca;
   localparam logic [12:0] SLE_F_CHAN_STEP = 13'h000a;
   localparam logic [12:0] SLE_F_LO_BASE = 13'h1204;
   localparam logic [12:0] SLE_F_HI_BASE = 13'h1304;
   // Timing
   localparam int SLE_CLK_NS = 10;
   localparam int SLE_CF_NS = 8000;
   localparam int SLE_DCU_NS = 6000;
   localparam int SLE_SETTLE_NS = 32000;
   localparam int SLE_CW = 12;
   localparam logic [11:0] SLE_CF_CYC = 12'((SLE_CF_NS + SLE_CLK_NS - 1) / SLE_CLK_NS);
   localparam logic [11:0] SLE_DCU_CYC = 12'((SLE_DCU_NS + SLE_CLK_NS - 1) / SLE_CLK_NS);
   localparam logic [11:0] SLE_SETTLE_CYC = 12'((SLE_SETTLE_NS + SLE_CLK_NS - 1) / SLE_CLK_NS);

   typedef enum logic [3:0] {
      radio_off_state,
      synth_on_state,
      listen_state,
      auto_retry_tx_idle_state,
      auto_ack_rx_idle_state,
      transmitting_state,
      auto_retry_transmitting_state,
      receiving_state,
      auto_ack_receiving_state
   } sle_trx_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } sle_reg_req_t;

   typedef struct packed {
      logic valid;
      sle_trx_state_t target;
   } sle_force_t;
endpackage

// ---- sle_synth_ctrl.sv ----
// Synthesizer lock events, frequency selection and calibration start control
module sle_synth_ctrl (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire sle_pkg::sle_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   // Radio state machine
   input wire sle_pkg::sle_trx_state_t trx_state,
   output sle_pkg::sle_force_t trx_force,
   // Synthesizer
   input wire logic pll_lock_raw,
   output logic [12:0] synth_freq,
   output logic cf_cal_run,
   output logic dcu_cal_run
);
   import sle_pkg::*;

   typedef enum logic [0:0] {
      SLE_RQ_IDLE,
      SLE_RQ_WAIT
   } sle_rq_t;

   logic lk_m_q, lk_s_q, lk_p_q;
   logic [7:0] chan_q, chan_d, num_q, num_d, cf_q, cf_d, dcu_q, dcu_d, rdata_q, rdata_d;
   logic [3:0] band_q, band_d;
   logic [12:0] freq_q, freq_d, new_freq;
   logic new_ok;
   logic [11:0] cf_cnt_q, cf_cnt_d, dcu_cnt_q, dcu_cnt_d, set_cnt_q, set_cnt_d;
   logic cf_man_q, cf_man_d, arm_q, arm_d, lkf_q, lkf_d, ulf_q, ulf_d;
   sle_trx_state_t prev_q;
   sle_rq_t rq_q, rq_d;
   sle_trx_state_t tgt_q, tgt_d;
   sle_force_t force_q, force_d;

   logic in_four, in_on_listen, was_tx, in_tx, in_rx, enter_active, tx_done;
   logic freq_chg, auto_start, cf_start_man, dcu_start_man, cf_end, dcu_end, cf_busy;
   logic cf_man_done, settling, lk_rise, lk_fall, lock_evt, unlock_evt, irq_rd;

   // Lock comes from the analog side, so it is synchronised first
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lk_m_q <= 1'b0;
         lk_s_q <= 1'b0;
         lk_p_q <= 1'b0;
      end else begin
         lk_m_q <= pll_lock_raw;
         lk_s_q <= lk_m_q;
         lk_p_q <= lk_s_q;
      end
   end

   // State classification
   always_comb begin
      in_four = (trx_state == synth_on_state) || (trx_state == listen_state) ||
                (trx_state == auto_retry_tx_idle_state) || (trx_state == auto_ack_rx_idle_state);
      in_on_listen = (trx_state == synth_on_state) || (trx_state == listen_state);
      in_tx = (trx_state == transmitting_state) || (trx_state == auto_retry_transmitting_state);
      in_rx = (trx_state == receiving_state) || (trx_state == auto_ack_receiving_state);
      was_tx = (prev_q == transmitting_state) || (prev_q == auto_retry_transmitting_state);
      enter_active = (prev_q == radio_off_state) && in_four;
      tx_done = was_tx && ((trx_state == synth_on_state) ||
                           (trx_state == auto_retry_tx_idle_state));
   end

   // Frequency from channel or alternative band; reserved settings keep the old tuning
   always_comb begin
      new_freq = freq_q;
      new_ok = 1'b0;
      case (band_q)
         SLE_BAND_CHAN: begin
            if (chan_q[4:0] >= SLE_CHAN_MIN && chan_q[4:0] <= SLE_CHAN_MAX) begin
               new_freq = 13'(SLE_F_CHAN_BASE +
                              SLE_F_CHAN_STEP * 13'(chan_q[4:0] - SLE_CHAN_MIN));
               new_ok = 1'b1;
            end
         end
         SLE_BAND_LO: begin
            if (num_q >= SLE_LO_MIN) begin
               new_freq = 13'(SLE_F_LO_BASE + 13'(num_q));
               new_ok = 1'b1;
            end
         end
         SLE_BAND_HI: begin
            if (num_q <= SLE_HI_MAX) begin
               new_freq = 13'(SLE_F_HI_BASE + 13'(num_q));
               new_ok = 1'b1;
            end
         end
         default: begin
            new_ok = 1'b0;
         end
      endcase
      freq_chg = new_ok && (new_freq != freq_q);
      freq_d = freq_chg ? new_freq : freq_q;
   end

   // Calibration timers and start bits
   always_comb begin
      cf_start_man = reg_req.wr && (reg_req.addr == SLE_ADDR_CF) && reg_req.wdata[SLE_BIT_GO];
      dcu_start_man = reg_req.wr && (reg_req.addr == SLE_ADDR_DCU) &&
                      reg_req.wdata[SLE_BIT_GO];
      auto_start = freq_chg || enter_active;
      cf_end = (cf_cnt_q == 12'h001);
      dcu_end = (dcu_cnt_q == 12'h001);
      cf_busy = (cf_cnt_q != 12'h000);
      cf_man_done = cf_end && cf_man_q;
      if (auto_start || cf_start_man) begin
         cf_cnt_d = SLE_CF_CYC;
      end else if (cf_busy) begin
         cf_cnt_d = cf_cnt_q - 12'h001;
      end else begin
         cf_cnt_d = cf_cnt_q;
      end
      if (auto_start || dcu_start_man) begin
         dcu_cnt_d = SLE_DCU_CYC;
      end else if (dcu_cnt_q != 12'h000) begin
         dcu_cnt_d = dcu_cnt_q - 12'h001;
      end else begin
         dcu_cnt_d = dcu_cnt_q;
      end
      if (cf_start_man) begin
         cf_man_d = 1'b1;
      end else if (cf_end) begin
         cf_man_d = 1'b0;
      end else begin
         cf_man_d = cf_man_q;
      end
      if (tx_done) begin
         set_cnt_d = SLE_SETTLE_CYC;
      end else if (set_cnt_q != 12'h000) begin
         set_cnt_d = set_cnt_q - 12'h001;
      end else begin
         set_cnt_d = set_cnt_q;
      end
      settling = (set_cnt_q != 12'h000);
   end

   // Registers; reserved bits store what was written, except band bits 7:4 and DCU bit 6, which stay zero
   always_comb begin
      chan_d = chan_q;
      num_d = num_q;
      band_d = band_q;
      cf_d = cf_q;
      dcu_d = dcu_q;
      if (reg_req.wr) begin
         case (reg_req.addr)
            SLE_ADDR_CHAN: chan_d = reg_req.wdata;
            SLE_ADDR_NUM: num_d = reg_req.wdata;
            SLE_ADDR_BAND: band_d = reg_req.wdata[3:0];
            SLE_ADDR_CF: cf_d = reg_req.wdata;
            SLE_ADDR_DCU: dcu_d = reg_req.wdata;
            default: chan_d = chan_q;
         endcase
      end
      dcu_d[SLE_BIT_DCU_RO] = 1'b0;
      // The end of a run clears the bit, but a fresh start in the same cycle wins
      if (cf_end && cf_man_q && !cf_start_man) begin
         cf_d[SLE_BIT_GO] = 1'b0;
      end
      if (dcu_end && !dcu_start_man) begin
         dcu_d[SLE_BIT_GO] = 1'b0;
      end
   end

   // Event sources and status flags
   always_comb begin
      lk_rise = lk_s_q && !lk_p_q;
      lk_fall = !lk_s_q && lk_p_q;
      // Expected lock waits for the synthesizer and any running center calibration
      lock_evt = !settling && (cf_man_done ||
                 (arm_q && lk_s_q && !cf_busy) ||
                 (lk_rise && !arm_q && !cf_busy));
      unlock_evt = ((cf_start_man || freq_chg) && in_on_listen) ||
                   (lk_fall && !settling && !cf_busy && !arm_q);
      if (enter_active || (freq_chg && in_four)) begin
         arm_d = 1'b1;
      end else if (arm_q && lk_s_q && !cf_busy && !settling) begin
         arm_d = 1'b0;
      end else begin
         arm_d = arm_q;
      end
      irq_rd = reg_req.rd && (reg_req.addr == SLE_ADDR_IRQ);
      // Set wins over the read clear; each event wipes the other flag
      lkf_d = lock_evt ? 1'b1 : ((unlock_evt || irq_rd) ? 1'b0 : lkf_q);
      ulf_d = (unlock_evt && !lock_evt) ? 1'b1 :
              ((lock_evt || irq_rd) ? 1'b0 : ulf_q);
   end

   // Forced state changes on lock events during busy states
   always_comb begin
      rq_d = rq_q;
      tgt_d = tgt_q;
      force_d = '{valid: 1'b0, target: tgt_q};
      case (rq_q)
         SLE_RQ_IDLE: begin
            if ((lock_evt || unlock_evt) && in_tx) begin
               force_d = '{valid: 1'b1, target: synth_on_state};
            end else if ((lock_evt || unlock_evt) && in_rx) begin
               rq_d = SLE_RQ_WAIT;
               tgt_d = (trx_state == receiving_state) ? listen_state : auto_ack_rx_idle_state;
            end
         end
         SLE_RQ_WAIT: begin
            // Hold off until the synthesizer reports lock again
            if (lk_s_q && !cf_busy) begin
               force_d = '{valid: 1'b1, target: tgt_q};
               rq_d = SLE_RQ_IDLE;
            end
         end
         default: rq_d = SLE_RQ_IDLE;
      endcase
   end

   // Read data, registered
   always_comb begin
      rdata_d = rdata_q;
      if (reg_req.rd) begin
         case (reg_req.addr)
            SLE_ADDR_CHAN: rdata_d = chan_q;
            SLE_ADDR_IRQ: rdata_d = {6'h00, ulf_q, lkf_q};
            SLE_ADDR_NUM: rdata_d = num_q;
            SLE_ADDR_BAND: rdata_d = {4'h0, band_q};
            SLE_ADDR_CF: rdata_d = cf_q;
            SLE_ADDR_DCU: rdata_d = dcu_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         chan_q <= SLE_RST_CHAN;
         num_q <= SLE_RST_NUM;
         band_q <= SLE_RST_BAND;
         cf_q <= SLE_RST_CF;
         dcu_q <= SLE_RST_DCU;
         rdata_q <= 8'h00;
         freq_q <= SLE_F_CHAN_BASE;
         cf_cnt_q <= 12'h000;
         dcu_cnt_q <= 12'h000;
         set_cnt_q <= 12'h000;
         cf_man_q <= 1'b0;
         arm_q <= 1'b0;
         lkf_q <= 1'b0;
         ulf_q <= 1'b0;
         prev_q <= radio_off_state;
         rq_q <= SLE_RQ_IDLE;
         tgt_q <= listen_state;
         force_q <= '{valid: 1'b0, target: synth_on_state};
      end else begin
         chan_q <= chan_d;
         num_q <= num_d;
         band_q <= band_d;
         cf_q <= cf_d;
         dcu_q <= dcu_d;
         rdata_q <= rdata_d;
         freq_q <= freq_d;
         cf_cnt_q <= cf_cnt_d;
         dcu_cnt_q <= dcu_cnt_d;
         set_cnt_q <= set_cnt_d;
         cf_man_q <= cf_man_d;
         arm_q <= arm_d;
         lkf_q <= lkf_d;
         ulf_q <= ulf_d;
         prev_q <= trx_state;
         rq_q <= rq_d;
         tgt_q <= tgt_d;
         force_q <= force_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign trx_force = force_q;
   assign synth_freq = freq_q;
   assign cf_cal_run = cf_busy;
   assign dcu_cal_run = (dcu_cnt_q != 12'h000);
endmodule

// ---- sle_unused_placeholder_never.sv ----
// Empty compile unit kept out

// ---- sle_end.sv ----
// End of design files

// ---- sle_synth_ctrl_monitor.sv ----
// Assertion checker for the synthesizer lock and frequency control block
module sle_synth_ctrl_monitor
   import sle_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire sle_pkg::sle_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   // Radio state machine
   input wire sle_pkg::sle_trx_state_t trx_state,
   input wire sle_pkg::sle_force_t trx_force,
   // Synthesizer
   input wire logic pll_lock_raw,
   input wire logic [12:0] synth_freq,
   input wire logic cf_cal_run,
   input wire logic dcu_cal_run
);
   logic [11:0] cf_n_q, cf_n_d, dc_n_q, dc_n_d;
   // Run lengths of the calibration timers
   always_comb begin
      cf_n_d = cf_cal_run ? cf_n_q + 12'h001 : 12'h000;
      dc_n_d = dcu_cal_run ? dc_n_q + 12'h001 : 12'h000;
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cf_n_q <= 12'h000;
         dc_n_q <= 12'h000;
      end else begin
         cf_n_q <= cf_n_d;
         dc_n_q <= dc_n_d;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   AST_FORCE_PULSE: assert property (trx_force.valid |=> !trx_force.valid)
      else $error("force pulse longer than one cycle");
   AST_FORCE_SRC: assert property (trx_force.valid |-> $past(trx_state) inside
      {transmitting_state, auto_retry_transmitting_state, receiving_state,
      auto_ack_receiving_state}) else $error("force outside busy states");
   AST_TX_TARGET: assert property (trx_force.valid && $past(trx_state) inside
      {transmitting_state, auto_retry_transmitting_state} |->
      trx_force.target == synth_on_state) else $error("abort target wrong");
   AST_RX_TARGET: assert property (trx_force.valid && $past(trx_state) inside
      {receiving_state, auto_ack_receiving_state} |-> trx_force.target ==
      ($past(trx_state) == receiving_state ? listen_state : auto_ack_rx_idle_state))
      else $error("receive return target wrong");
   AST_CAL_ON_FREQ: assert property ($changed(synth_freq) |-> cf_cal_run && dcu_cal_run)
      else $error("frequency moved without calibrations");
   AST_FREQ_HOLD: assert property (!$past(reg_req.wr, 2) |-> $stable(synth_freq))
      else $error("frequency moved without a write");
   AST_IRQ_ONE: assert property (reg_req.rd && reg_req.addr == SLE_ADDR_IRQ |=>
      !(reg_rdata[SLE_BIT_LOCK] && reg_rdata[SLE_BIT_UNLOCK]))
      else $error("lock and unlock flags both set");
   AST_BAND_UPPER: assert property (reg_req.rd && reg_req.addr == SLE_ADDR_BAND |=>
      reg_rdata[7:4] == 4'h0) else $error("band upper bits not zero");
   AST_CF_LEN: assert property ($fell(cf_cal_run) |->
      cf_n_q inside {[SLE_CF_CYC - 12'h001:SLE_CF_CYC + 12'h001]})
      else $error("centre calibration length wrong");
   AST_DCU_LEN: assert property ($fell(dcu_cal_run) |->
      dc_n_q inside {[SLE_DCU_CYC - 12'h001:SLE_DCU_CYC + 12'h001]})
      else $error("delay calibration length wrong");
endmodule

bind sle_synth_ctrl sle_synth_ctrl_monitor sle_synth_ctrl_monitor_i (.ref_clk, .rst_n,
   .reg_req, .reg_rdata, .trx_state, .trx_force, .pll_lock_raw, .synth_freq, .cf_cal_run,
   .dcu_cal_run);

// ---- sle_synth_ctrl_tb.sv ----
// Self-checking testbench for the synthesizer lock and frequency control block
module sle_synth_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sle_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic pll_lock_raw = 1'b1;
   sle_reg_req_t reg_req = '0;
   sle_trx_state_t trx_state = radio_off_state;
   logic [7:0] reg_rdata;
   sle_force_t trx_force, fr;
   logic [12:0] synth_freq, f;
   logic cf_cal_run, dcu_cal_run;
   logic [7:0] d, x, n, cv;
   logic [3:0] b;
   bit got;
   int fails = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [5:0] ra[6] = '{SLE_ADDR_CHAN, SLE_ADDR_NUM, SLE_ADDR_BAND, SLE_ADDR_CF,
      SLE_ADDR_DCU, 6'h3d};
   logic [7:0] rv[6] = '{SLE_RST_CHAN, SLE_RST_NUM, {4'h0, SLE_RST_BAND}, SLE_RST_CF,
      SLE_RST_DCU, 8'h00};
   logic [3:0] bt[8] = '{4'h8, 4'h9, 4'h8, 4'h3, 4'h0, 4'h9, 4'hf, 4'h0};
   sle_trx_state_t fs[4] = '{transmitting_state, auto_retry_transmitting_state,
      receiving_state, auto_ack_receiving_state};
   sle_trx_state_t ft[4] = '{synth_on_state, synth_on_state, listen_state,
      auto_ack_rx_idle_state};
   sle_trx_state_t js[4] = '{synth_on_state, listen_state, auto_retry_tx_idle_state,
      auto_ack_rx_idle_state};
   always #5 ref_clk = ~ref_clk;
   sle_synth_ctrl sle_synth_ctrl_i (.ref_clk, .rst_n, .reg_req, .reg_rdata, .trx_state,
      .trx_force, .pll_lock_raw, .synth_freq, .cf_cal_run, .dcu_cal_run);
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Spare cycle first, so back-to-back calls never retoggle a strobe in one step
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      @(negedge ref_clk);
      reg_req = '{1'b1, 1'b0, a, v};
      @(negedge ref_clk);
      reg_req.wr = 1'b0;
   endtask
   task automatic rd(input logic [5:0] a);
      @(negedge ref_clk);
      reg_req = '{1'b0, 1'b1, a, 8'h00};
      @(negedge ref_clk);
      reg_req.rd = 1'b0;
      d = reg_rdata;
   endtask
   // Bounded wait for both calibration timers, plus room for the lock event
   task automatic idle;
      int k = 0;
      @(negedge ref_clk);
      while ((cf_cal_run !== 1'b0 || dcu_cal_run !== 1'b0) && k < 2000) begin
         @(negedge ref_clk);
         k++;
      end
      repeat (4) @(negedge ref_clk);
   endtask
   // Returns at the negedge the pulse is seen, so the state can follow at once
   task automatic wforce(input int m);
      got = 0;
      for (int i = 0; i < m && !got; i++) begin
         @(negedge ref_clk);
         if (trx_force.valid === 1'b1) begin
            got = 1;
            fr = trx_force;
         end
      end
   endtask
   function automatic logic [12:0] efreq(logic [7:0] c, logic [7:0] m, logic [3:0] s,
                                         logic [12:0] o);
      if (s == 4'h0 && c[4:0] inside {[5'h0b:5'h1a]}) return 13'(4810 + 10 * (c[4:0] - 11));
      if (s == 4'h8 && m >= 8'h20) return 13'(2306 * 2 + m);
      if (s == 4'h9 && m <= 8'hba) return 13'(2434 * 2 + m);
      return o;
   endfunction
   task automatic results;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 60000) begin
         fails++;
         results();
      end
   end
   initial begin
      void'($urandom(32'haa19a62c));
      repeat (10) @(negedge ref_clk);
      rst_n = 1'b1;
      @(negedge ref_clk);
      foreach (ra[i]) begin
         rd(ra[i]);
         chk(d, rv[i]);
      end
      f = 13'(2405 * 2);
      chk(synth_freq, f);
      for (int i = 0; i < 12; i++) begin
         x = 8'($urandom);
         if (i < 3) x[4:0] = i == 0 ? 5'h1a : (i == 1 ? 5'h1b : 5'h0b);
         // Valid last channel, so the later channel writes always retune
         if (i == 11) x[4:0] = 5'h0c;
         wr(SLE_ADDR_CHAN, x);
         idle();
         f = efreq(x, 8'h00, 4'h0, f);
         chk(synth_freq, f);
         rd(SLE_ADDR_CHAN);
         chk(d, x);
         cv = x;
      end
      b = 4'h0;
      for (int i = 0; i < 8; i++) begin
         n = i == 0 ? 8'h1f : (i == 1 ? 8'hba : 8'($urandom));
         wr(SLE_ADDR_NUM, n);
         idle();
         f = efreq(cv, n, b, f);
         chk(synth_freq, f);
         x = {4'($urandom), bt[i]};
         wr(SLE_ADDR_BAND, x);
         idle();
         b = bt[i];
         f = efreq(cv, n, b, f);
         chk(synth_freq, f);
         rd(SLE_ADDR_BAND);
         chk(d, {4'h0, b});
      end
      rd(SLE_ADDR_IRQ);
      trx_state = synth_on_state;
      idle();
      rd(SLE_ADDR_IRQ);
      chk(d, 8'h01);
      // Unlock only in synth-on and listen; second pass leaves it for the lock to wipe
      for (int j = 0; j < 4; j++) begin
         trx_state = js[j];
         wr(SLE_ADDR_CHAN, 8'h11 + 8'(j));
         repeat (2) @(negedge ref_clk);
         if (j != 1) rd(SLE_ADDR_IRQ);
         if (j != 1) chk(d, j == 0 ? 8'h02 : 8'h00);
         idle();
         rd(SLE_ADDR_IRQ);
         chk(d, 8'h01);
      end
      trx_state = listen_state;
      rd(SLE_ADDR_CF);
      x = d | 8'h80;
      wr(SLE_ADDR_CF, x);
      rd(SLE_ADDR_CF);
      chk(d, x);
      chk(cf_cal_run, 1'b1);
      rd(SLE_ADDR_IRQ);
      chk(d, 8'h02);
      idle();
      rd(SLE_ADDR_CF);
      chk(d, x & 8'h7f);
      rd(SLE_ADDR_IRQ);
      chk(d, 8'h01);
      rd(SLE_ADDR_DCU);
      x = d | 8'hc0;
      wr(SLE_ADDR_DCU, x);
      rd(SLE_ADDR_DCU);
      chk(d, x & 8'hbf);
      chk(dcu_cal_run, 1'b1);
      chk(cf_cal_run, 1'b0);
      idle();
      rd(SLE_ADDR_DCU);
      chk(d, x & 8'h3f);
      pll_lock_raw = 1'b0;
      repeat (6) @(negedge ref_clk);
      rd(SLE_ADDR_IRQ);
      chk(d, 8'h02);
      pll_lock_raw = 1'b1;
      repeat (6) @(negedge ref_clk);
      rd(SLE_ADDR_IRQ);
      chk(d, 8'h01);
      foreach (fs[i]) begin
         trx_state = fs[i];
         pll_lock_raw = 1'b0;
         wforce(20);
         if (i >= 2) begin
            chk(got, 1'b0);
            pll_lock_raw = 1'b1;
            wforce(20);
         end
         chk(got, 1'b1);
         chk(fr.target, ft[i]);
         trx_state = ft[i];
         pll_lock_raw = 1'b1;
         if (i < 2) begin
            repeat (8) @(negedge ref_clk);
            rd(SLE_ADDR_IRQ);
            chk(d, 8'h02);
            repeat (3300) @(negedge ref_clk);
         end
      end
      results();
   end
endmodule
